// [design/sms_sequencer.sv]
// Sensor measurement sequencer with its ten-bit converter control.
// How it works
// - Ten-bit successive-approximation converter with sample-and-hold, six selectable input channels.
// - Channel wiring is fixed: pressure/accel, temperature, band gap, two pins, regulator.
// - Pressure and acceleration go through the interface; others start directly from processor.
// - Selected sensing element powered and allowed to settle before conversion starts.
// - Conversion starts and ends aligned with sampling of the input voltage.
// - Processor sets control then stops; completion raises a wake interrupt.
// - Pressure request powers pressure cell, samples it, converts it.
// - Acceleration request powers acceleration cell, samples it, converts it.
// - Only one sensor connected and measured at a time.
// - Temperature is converted on channel 1.
// - Acceleration results carry a four-bit offset step identifier, 0 to 15.
// - Acceleration codes 1 to 510 valid; 0 and 511 flagged as faults in 9-bit results.
// - Results delivered as 8-, 9- or 10-bit values per request.
module sms_sequencer
	import sms_pkg::*;
(
	input  wire logic              clk_sys_i,     // Bus clock, 100 MHz.
	input  wire logic              nrst_i,        // Asynchronous reset, active low.
	input  wire logic              req_i,         // One-cycle measurement request.
	input  wire sms_req_s          req_cfg_i,     // Request source, channel, step, width.
	output logic                   req_ready_o,   // High while a request may be taken.
	output logic                   press_pwr_o,   // Pressure cell power enable.
	output logic                   accel_pwr_o,   // Acceleration cell power enable.
	output logic [STEP_W-1:0]      accel_step_o,  // Offset step applied to acceleration path.
	output logic [CH_W-1:0]        adc_chan_o,    // Converter input select.
	output logic                   adc_sample_o,  // Sample-and-hold track strobe.
	input  wire logic              sar_cmp_i,     // Comparator output, asynchronous.
	output logic [ADC_W-1:0]       sar_dac_o,     // Trial code to the converter DAC.
	output sms_res_s               result_o,      // Last result.
	output logic                   result_vld_o,  // One-cycle pulse with a new result.
	output logic                   wake_irq_o     // Completion interrupt, one cycle.
);

	////////////////////////////////////////////////////////////////////////////
	sms_state_e          state_r;
	sms_req_s            cur_r;
	logic [CNT_W-1:0]    cnt_r;
	logic [ADC_W-1:0]    sar_r;
	logic [ADC_W-1:0]    bit_r;
	logic                cmp_meta_r;
	logic                cmp_sync_r;
	logic                take;

	// Requests are taken only in idle, so a request during a measurement is dropped.
	assign take = req_i && (state_r == SMS_IDLE);

	// The comparator is analog, so it is synchronised before use.
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cmp_meta_r <= 1'b0;
			cmp_sync_r <= 1'b0;
		end
		else
		begin
			cmp_meta_r <= sar_cmp_i;
			cmp_sync_r <= cmp_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_r <= SMS_IDLE;
			cur_r   <= '0;
			cnt_r   <= '0;
		end
		else
		begin
			case (state_r)
				SMS_IDLE:
				begin
					if (take)
					begin
						cur_r <= req_cfg_i;
						// Interface-driven sources are forced onto channel 0.
						if (req_cfg_i.src != SMS_SRC_DIRECT)
							cur_r.chan <= CH_PRESS_ACCEL;
						else if (req_cfg_i.chan > CH_LAST)
							cur_r.chan <= CH_REG_MON;
						if (req_cfg_i.src == SMS_SRC_DIRECT)
						begin
							// Processor-run captures skip the cell power phase.
							state_r <= SMS_SAMPLE;
							cnt_r   <= CNT_W'(SAMPLE_CYC - 1);
						end
						else
						begin
							state_r <= SMS_SETTLE;
							cnt_r   <= CNT_W'(SETTLE_CYC - 1);
						end
					end
				end
				SMS_SETTLE:
				begin
					if (cnt_r == '0)
					begin
						state_r <= SMS_SAMPLE;
						cnt_r   <= CNT_W'(SAMPLE_CYC - 1);
					end
					else
						cnt_r <= cnt_r - 1'b1;
				end
				SMS_SAMPLE:
				begin
					// Conversion begins on the cycle the hold closes.
					if (cnt_r == '0)
					begin
						state_r <= SMS_CONV;
						cnt_r   <= CNT_W'(CMP_WAIT_CYC);
					end
					else
						cnt_r <= cnt_r - 1'b1;
				end
				SMS_CONV:
				begin
					// Each trial waits for the DAC register and the comparator synchroniser.
					// This costs four cycles per bit but keeps every decision on its own trial.
					if (bit_r == '0)
						state_r <= SMS_DONE;
					else if (cnt_r == '0)
						cnt_r <= CNT_W'(CMP_WAIT_CYC);
					else
						cnt_r <= cnt_r - 1'b1;
				end
				SMS_DONE:
					state_r <= SMS_IDLE;
				default:
					state_r <= SMS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Successive approximation, one bit every four cycles, MSB first.
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sar_r <= '0;
			bit_r <= '0;
		end
		else if (state_r == SMS_SAMPLE && cnt_r == '0)
		begin
			sar_r <= {1'b1, {(ADC_W-1){1'b0}}};
			bit_r <= {1'b1, {(ADC_W-1){1'b0}}};
		end
		else if (state_r == SMS_CONV && bit_r != '0 && cnt_r == '0)
		begin
			// The trial reaches the DAC one cycle late and the comparator two more.
			// Deciding only when the wait count runs out judges the current trial.
			sar_r <= (cmp_sync_r ? sar_r : (sar_r & ~bit_r)) | (bit_r >> 1);
			bit_r <= bit_r >> 1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog controls: only one cell is ever powered.
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			press_pwr_o  <= 1'b0;
			accel_pwr_o  <= 1'b0;
			accel_step_o <= '0;
			adc_chan_o   <= CH_PRESS_ACCEL;
			adc_sample_o <= 1'b0;
			sar_dac_o    <= '0;
			req_ready_o  <= 1'b0;
		end
		else
		begin
			press_pwr_o  <= (state_r != SMS_IDLE && state_r != SMS_DONE) &&
				cur_r.src == SMS_SRC_PRESS;
			accel_pwr_o  <= (state_r != SMS_IDLE && state_r != SMS_DONE) &&
				cur_r.src == SMS_SRC_ACCEL;
			accel_step_o <= cur_r.step;
			adc_chan_o   <= cur_r.chan;
			adc_sample_o <= (state_r == SMS_SAMPLE) && (cnt_r != '0);
			sar_dac_o    <= sar_r;
			req_ready_o  <= (state_r == SMS_IDLE) && !req_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result formatting and completion interrupt.
	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			result_o     <= '0;
			result_vld_o <= 1'b0;
			wake_irq_o   <= 1'b0;
		end
		else
		begin
			result_vld_o <= (state_r == SMS_DONE);
			wake_irq_o   <= (state_r == SMS_DONE);
			if (state_r == SMS_DONE)
			begin
				result_o.chan  <= cur_r.chan;
				result_o.step  <= (cur_r.src == SMS_SRC_ACCEL) ? cur_r.step : '0;
				result_o.fault <= 1'b0;
				case (cur_r.fmt)
					SMS_FMT_8:  result_o.data <= {2'b00, sar_r[ADC_W-1 -: 8]};
					SMS_FMT_9:
					begin
						result_o.data <= {1'b0, sar_r[ADC_W-1 -: ACC_CODE_W]};
						if (cur_r.src == SMS_SRC_ACCEL)
							result_o.fault <= sar_r[ADC_W-1 -: ACC_CODE_W] == ACC_CODE_LOW_FAULT ||
								sar_r[ADC_W-1 -: ACC_CODE_W] == ACC_CODE_HIGH_FAULT;
					end
					default:    result_o.data <= sar_r;
				endcase
			end
		end
	end

endmodule // sms_sequencer

// [inc/sms_pkg.sv]
// Package of constants and carrier types for the sensor measurement sequencer.
package sms_pkg;

	localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
	// Settle time of a sensing element after power up, in microseconds.
	localparam int unsigned SETTLE_US     = 40;
	localparam int unsigned SETTLE_CYC    = (SETTLE_US * (CLK_FREQ_HZ / 1_000_000) > 0)
		? SETTLE_US * (CLK_FREQ_HZ / 1_000_000) : 1;
	// Sample-and-hold acquisition time, in nanoseconds.
	localparam int unsigned SAMPLE_NS     = 1000;
	localparam int unsigned SAMPLE_CYC    = (SAMPLE_NS * (CLK_FREQ_HZ / 1_000_000) / 1000 > 0)
		? SAMPLE_NS * (CLK_FREQ_HZ / 1_000_000) / 1000 : 1;
	localparam int unsigned CNT_W         = 13;
	// Cycles from a new DAC trial until the synchronised comparator answers it.
	localparam int unsigned CMP_WAIT_CYC  = 3;

	localparam int unsigned ADC_W         = 10;
	localparam int unsigned CH_W          = 3;
	localparam int unsigned STEP_W        = 4;
	localparam int unsigned ACC_CODE_W    = 9;

	localparam logic [CH_W-1:0] CH_PRESS_ACCEL = 3'h0;
	localparam logic [CH_W-1:0] CH_TEMP        = 3'h1;
	localparam logic [CH_W-1:0] CH_BANDGAP     = 3'h2;
	localparam logic [CH_W-1:0] CH_PIN_ZERO    = 3'h3;
	localparam logic [CH_W-1:0] CH_PIN_ONE     = 3'h4;
	localparam logic [CH_W-1:0] CH_REG_MON     = 3'h5;
	localparam logic [CH_W-1:0] CH_LAST        = 3'h5;

	localparam logic [ACC_CODE_W-1:0] ACC_CODE_LOW_FAULT  = 9'h000;
	localparam logic [ACC_CODE_W-1:0] ACC_CODE_HIGH_FAULT = 9'h1ff;

	// Result widths the processor may ask for.
	typedef enum logic [1:0] {
		SMS_FMT_8  = 2'b00,
		SMS_FMT_9  = 2'b01,
		SMS_FMT_10 = 2'b10
	} sms_fmt_e;

	typedef enum logic [1:0] {
		SMS_SRC_PRESS = 2'b00,
		SMS_SRC_ACCEL = 2'b01,
		SMS_SRC_DIRECT = 2'b10
	} sms_src_e;

	typedef struct packed {
		sms_src_e          src;
		logic [CH_W-1:0]   chan;
		logic [STEP_W-1:0] step;
		sms_fmt_e          fmt;
	} sms_req_s;

	typedef struct packed {
		logic [ADC_W-1:0]  data;
		logic [CH_W-1:0]   chan;
		logic [STEP_W-1:0] step;
		logic              fault;
	} sms_res_s;

	typedef enum logic [2:0] {
		SMS_IDLE   = 3'b000,
		SMS_SETTLE = 3'b001,
		SMS_SAMPLE = 3'b010,
		SMS_CONV   = 3'b011,
		SMS_DONE   = 3'b100
	} sms_state_e;

endpackage : sms_pkg

// [verification/sms_analog_model.sv]
// Comparator model of the analog side of the converter.
module sms_analog_model
	import sms_pkg::*;
(
	input  wire logic [ADC_W-1:0] dac_i, // Trial code.
	input  wire logic [ADC_W-1:0] vin_i, // Held input.
	output logic                  cmp_o  // Keep bit.
);
	timeunit 1ns / 1ps;
	// The input is held for a whole measurement, so the trial never chases a moving level.
	assign cmp_o = (dac_i <= vin_i);
endmodule // sms_analog_model

// [verification/sms_sequencer_assertions.sv]
// Port checks of the sensor measurement sequencer.
module sms_checker
	import sms_pkg::*;
(
	input wire logic            clk_sys_i,    // Clock.
	input wire logic            nrst_i,       // Reset.
	input wire logic            req_ready_o,  // Ready.
	input wire logic            press_pwr_o,  // Cell power.
	input wire logic            accel_pwr_o,  // Cell power.
	input wire logic [CH_W-1:0] adc_chan_o,   // Channel.
	input wire logic            adc_sample_o, // Sample.
	input wire sms_res_s        result_o,     // Result.
	input wire logic            result_vld_o, // New result.
	input wire logic            wake_irq_o    // Interrupt.
);
	timeunit 1ns / 1ps;
	// Cycles from the hold closing to the result pulse: ten trials, done and output register.
	localparam int CONV_LAT = ADC_W * (CMP_WAIT_CYC + 1) + 2;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	one_sensor_a: assert property (!(press_pwr_o && accel_pwr_o))
		else $error("both cells on");
	irq_result_a: assert property (wake_irq_o == result_vld_o)
		else $error("irq apart");
	busy_ready_a: assert property ((press_pwr_o || accel_pwr_o || adc_sample_o) |->
		!req_ready_o) else $error("ready while busy");
	cell_chan_a: assert property ((press_pwr_o || accel_pwr_o) |->
		adc_chan_o == CH_PRESS_ACCEL) else $error("cell off channel");
	settle_first_a: assert property ($rose(press_pwr_o || accel_pwr_o) |->
		!adc_sample_o [*8]) else $error("no settle");
	conv_span_a: assert property ($fell(adc_sample_o) |-> ##CONV_LAT result_vld_o)
		else $error("conversion late");
	fault_code_a: assert property (result_vld_o && result_o.fault |->
		result_o.data inside {10'h000, 10'h1ff}) else $error("bad fault");
	result_hold_a: assert property (!result_vld_o |-> $stable(result_o))
		else $error("result moved");
	cover property ($rose(press_pwr_o));
	cover property ($rose(accel_pwr_o));
	cover property (result_vld_o && result_o.fault);
endmodule // sms_checker

// [verification/sms_sequencer_test.sv]
// Self-checking bench of the sensor measurement sequencer.
module sms_sequencer_test
	import sms_pkg::*;
;
	timeunit 1ns / 1ps;
	logic             clk_sys_i = 1'b0;
	logic             nrst_i = 1'b0;
	logic             req_i = 1'b0;
	sms_req_s         req_cfg_i = '0;
	logic [ADC_W-1:0] vin = '0;
	logic [ADC_W-1:0] dac;
	logic             cmp, rdy, ppwr, apwr, vld, irq;
	logic [STEP_W-1:0] astep;
	logic [CH_W-1:0]  achan;
	sms_res_s         res;
	int               errors = 0;
	int               tests_run = 0;
	sms_sequencer dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_i(req_i),
		.req_cfg_i(req_cfg_i), .req_ready_o(rdy), .press_pwr_o(ppwr), .accel_pwr_o(apwr),
		.accel_step_o(astep), .adc_chan_o(achan), .adc_sample_o(), .sar_cmp_i(cmp), .sar_dac_o(dac),
		.result_o(res), .result_vld_o(vld), .wake_irq_o(irq));
	sms_analog_model afe (.dac_i(dac), .vin_i(vin), .cmp_o(cmp));
	initial forever #5 clk_sys_i = ~clk_sys_i;
	initial
	begin
		#500us;
		errors++;
		report_and_stop();
	end
	task automatic report_and_stop();
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic measure(input sms_src_e s, input logic [2:0] c, input logic [3:0] st,
		input sms_fmt_e f, input logic [9:0] v);
		sms_res_s   ex;
		logic [1:0] pw = 2'h0;
		int         n = 0;
		ex.data = v >> (2 - f);
		ex.chan = (s != SMS_SRC_DIRECT) ? CH_PRESS_ACCEL : (c > CH_LAST) ? CH_LAST : c;
		ex.step = (s == SMS_SRC_ACCEL) ? st : 4'h0;
		ex.fault = s == SMS_SRC_ACCEL && f == SMS_FMT_9 && ex.data inside {10'h000, 10'h1ff};
		while (rdy !== 1'b1 && n++ < 200) @(negedge clk_sys_i);
		@(posedge clk_sys_i);
		vin <= v;
		req_cfg_i <= '{s, c, st, f};
		req_i <= 1'b1;
		@(posedge clk_sys_i);
		req_i <= 1'b0;
		while (irq !== 1'b1 && n++ < 5000) @(negedge clk_sys_i) pw |= {ppwr, apwr};
		check(18'(vld), 18'h1);
		check(res, ex);
		check(18'(achan), 18'(ex.chan));
		check(18'(astep), 18'(st));
		check(18'(pw), 18'({s == SMS_SRC_PRESS, s == SMS_SRC_ACCEL}));
	endtask
	task automatic t_direct();
		for (int i = 1; i < 8; i++)
			measure(SMS_SRC_DIRECT, 3'(i), 4'h9, sms_fmt_e'(i % 3), 10'(i * 97));
	endtask
	task automatic t_cells();
		measure(SMS_SRC_PRESS, CH_TEMP, 4'h3, SMS_FMT_10, 10'h2a5);
		measure(SMS_SRC_ACCEL, CH_TEMP, 4'hf, SMS_FMT_9, 10'h000);
		measure(SMS_SRC_ACCEL, CH_TEMP, 4'h0, SMS_FMT_9, 10'h3ff);
		measure(SMS_SRC_ACCEL, CH_TEMP, 4'h7, SMS_FMT_9, 10'h003);
	endtask
	task automatic t_busy();
		int n = 0;
		fork
			measure(SMS_SRC_DIRECT, CH_PIN_ZERO, 4'h0, SMS_FMT_10, 10'h1c3);
			begin
				repeat (30) @(posedge clk_sys_i);
				req_i <= 1'b1;
				@(posedge clk_sys_i);
				req_i <= 1'b0;
			end
		join
		repeat (150) @(negedge clk_sys_i) n += int'(irq !== 1'b0);
		check(18'(n), 18'h0);
	endtask
	initial
	begin
		repeat (4) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		t_direct();
		t_cells();
		t_busy();
		report_and_stop();
	end
endmodule // sms_sequencer_test
bind sms_sequencer sms_checker chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
	.req_ready_o(req_ready_o), .press_pwr_o(press_pwr_o), .accel_pwr_o(accel_pwr_o),
	.adc_chan_o(adc_chan_o), .adc_sample_o(adc_sample_o), .result_o(result_o),
	.result_vld_o(result_vld_o), .wake_irq_o(wake_irq_o));
